// >>> hdl/sxrp_defines.svh
// Offsets, field positions and reset values of the secure partition register slice.
`ifndef SXRP_DEFINES_SVH
`define SXRP_DEFINES_SVH

`define SXRP_OFF_RESULT_LO 16'h8118
`define SXRP_OFF_RESULT_HI 16'h811C
`define SXRP_OFF_CAPABILITY 16'h8130
`define SXRP_OFF_GLOBAL_CFG 16'h8138

`define SXRP_RES_IMPL_HI 63
`define SXRP_RES_IMPL_LO 60
`define SXRP_RES_ADDR_HI 51
`define SXRP_RES_ADDR_LO 12
`define SXRP_RES_ADDR_TOP_LO 48
`define SXRP_RES_CODE_HI 11
`define SXRP_RES_CODE_LO 4
`define SXRP_RES_IAS_BIT 3
`define SXRP_RES_CLASS_HI 2
`define SXRP_RES_CLASS_LO 1
`define SXRP_RES_FAIL_BIT 0

`define SXRP_CAP_ALT_BIT 25
`define SXRP_CAP_GRP_HI 23
`define SXRP_CAP_GRP_LO 16
`define SXRP_CAP_PID_HI 15
`define SXRP_CAP_PID_LO 0

`define SXRP_CFG_UPDATE_BIT 31
`define SXRP_CFG_SPACE_BIT 24
`define SXRP_CFG_GRP_HI 23
`define SXRP_CFG_GRP_LO 16
`define SXRP_CFG_PID_HI 15
`define SXRP_CFG_PID_LO 0

`define SXRP_CFG_RESET 32'h0000_0000
`define SXRP_UPDATE_LATENCY 4'h2

`endif

// >>> hdl/sxrp_fault_if.sv
// Fault report carried from the capture logic to the result formatter.
`timescale 1ns/100ps
interface sxrp_fault_if;
	logic valid;
	sxrp_pkg::sxrp_fault_t fault;
	logic [63:0] word;

	modport capture (output valid, output fault, input word);
	modport format (input valid, input fault, output word);
endinterface : sxrp_fault_if

// >>> hdl/sxrp_id_width.sv
// Derives identifier widths from the limits and masks unsupported bits.
`timescale 1ns/100ps
module sxrp_id_width (
	input wire logic [7:0] grp_limit_i,
	input wire logic [15:0] pid_limit_i,
	output logic [4:0] grp_width_o,
	output logic [4:0] pid_width_o,
	output logic [7:0] grp_mask_o,
	output logic [15:0] pid_mask_o
);
	function automatic logic [4:0] sxrp_msb_width(input logic [15:0] v);
		logic [4:0] w;
		w = 5'h00;
		for (int i = 0; i < 16; i++) begin
			if (v[i]) begin
				w = 5'(i + 1);
			end
		end
		return w;
	endfunction : sxrp_msb_width

	function automatic logic [15:0] sxrp_width_mask(input logic [4:0] w);
		logic [16:0] m;
		m = (17'h0_0001 << w) - 17'h0_0001;
		return m[15:0];
	endfunction : sxrp_width_mask

	always_comb begin
		grp_width_o = sxrp_msb_width({8'h00, grp_limit_i}); // see R13
		pid_width_o = sxrp_msb_width(pid_limit_i); // see R14
		grp_mask_o = 8'(sxrp_width_mask(grp_width_o));
		pid_mask_o = sxrp_width_mask(pid_width_o);
	end
endmodule : sxrp_id_width

// >>> hdl/sxrp_pkg.sv
// Types shared by the secure partition register slice.
package sxrp_pkg;

	typedef enum logic [1:0] {
		SXRP_CLASS_S1_MISC = 2'h0,
		SXRP_CLASS_S2_DESC = 2'h1,
		SXRP_CLASS_S2_WALK = 2'h2,
		SXRP_CLASS_S2_INPUT = 2'h3
	} sxrp_class_t;

	typedef enum logic [2:0] {
		SXRP_UPD_IDLE = 3'h1,
		SXRP_UPD_WAIT = 3'h2,
		SXRP_UPD_DONE = 3'h4
	} sxrp_upd_state_t;

	typedef struct packed {
		logic [3:0] impl_bits;
		logic [39:0] page_addr;
		logic [7:0] code;
		logic s1_bypassed;
		logic input_ns;
		logic final_ns_s1;
		logic addr_valid;
		logic stream_secure;
		sxrp_class_t stage_class;
	} sxrp_fault_t;

endpackage : sxrp_pkg

// >>> hdl/sxrp_regs.sv
// Secure translation result and partition configuration register slice.
`timescale 1ns/100ps
`include "sxrp_defines.svh"

// Overview of operation
// R1: Fault result word holds impl bits, page address, code, space bit, class, flag.
// R2: Without 52-bit addressing, fault page address bits 51:48 read zero.
// R3: Secure stream with recorded address reports stage 1 final space bit.
// R4: When stage 1 was bypassed the request's input space bit is reported.
// R5: Space bit is zero with no reported address or non-secure stream.
// R6: Stage class 01 descriptor fetch, 10 table walk, 11 input, 00 other.
// R7: Failure flag bit 0 is one whenever the operation faulted.
// R8: Software leaves operation registers alone while an operation runs.
// R9: Software reads the result only while the active bit is clear.
// R10: Result and capability read zero for non-secure, read-only for secure.
// R11: Partition registers exist only with secure interface and partitioning.
// R12: Capability shows alt-space bit 25, group limit 23:16, id limit 15:0.
// R13: Group width is highest set bit of group limit plus one.
// R14: Identifier width is highest set bit of identifier limit plus one.
// R15: Partitioning should report a non-zero identifier limit.
// R16: Configuration bit 31 is the update flag, reset zero.
// R17: Bit 24 selects secure or non-secure space, zero without support.
// R18: Bits 23:16 give the internal monitor group, reset zero.
// R19: Group limit comes from non-secure capability when alt space selected.
// R20: Group bits above the supported width read zero.
// R21: Bits 15:0 give the internal partition identifier, reset zero.
// R22: Configuration writable by secure access only while update flag clear.
// R23: Device clears update flag once new identifiers are in force.
module sxrp_regs #(
	parameter bit SECURE_PRESENT = 1'b1,
	parameter bit PARTITION_PRESENT = 1'b1,
	parameter bit SECURE_S2 = 1'b1,
	parameter bit ADDR_52BIT = 1'b1,
	parameter bit ALT_SPACE = 1'b1,
	parameter logic [7:0] S_GRP_LIMIT = 8'h0F,
	parameter logic [15:0] S_PID_LIMIT = 16'h0034
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic reg_req_i,
	input wire logic reg_write_i,
	input wire logic reg_secure_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	output logic [31:0] reg_rdata_o,
	input wire logic op_active_i,
	input wire logic fault_valid_i,
	input wire logic [3:0] fault_impl_i,
	input wire logic [39:0] fault_addr_i,
	input wire logic fault_addr_valid_i,
	input wire logic [7:0] fault_code_i,
	input wire logic fault_stream_secure_i,
	input wire logic fault_s1_bypassed_i,
	input wire logic fault_input_ns_i,
	input wire logic fault_final_ns_i,
	input wire logic [1:0] fault_class_i,
	input wire logic [7:0] ns_grp_limit_i,
	input wire logic [15:0] ns_pid_limit_i,
	input wire logic apply_ack_i,
	output logic apply_req_o,
	output logic internal_space_ns_o,
	output logic [7:0] internal_monitor_group_o,
	output logic [15:0] internal_partition_id_o
);
	localparam bit PART_ON = SECURE_PRESENT && PARTITION_PRESENT;

	// ============================================================
	// Fault capture and formatting
	sxrp_fault_if flt ();
	logic [63:0] result_reg;
	logic [63:0] result_next;

	always_comb begin
		flt.valid = fault_valid_i;
		flt.fault.impl_bits = fault_impl_i;
		flt.fault.page_addr = fault_addr_i;
		flt.fault.code = fault_code_i;
		flt.fault.s1_bypassed = fault_s1_bypassed_i;
		flt.fault.input_ns = fault_input_ns_i;
		flt.fault.final_ns_s1 = fault_final_ns_i;
		flt.fault.addr_valid = fault_addr_valid_i;
		flt.fault.stream_secure = fault_stream_secure_i;
		flt.fault.stage_class = sxrp_pkg::sxrp_class_t'(fault_class_i);
	end

	sxrp_result_fmt #(
		.SECURE_S2(SECURE_S2),
		.ADDR_52BIT(ADDR_52BIT)
	) u_fmt (
		.flt(flt.format)
	);

	// The result is only latched on a fault; success format lives elsewhere.
	always_comb begin
		result_next = result_reg;
		if (flt.valid) begin
			result_next = flt.word; // see R7
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			result_reg <= 64'h0000_0000_0000_0000;
		end else begin
			result_reg <= result_next;
		end
	end

	// ============================================================
	// Capability values and identifier widths
	logic [31:0] cap_word;
	logic [7:0] grp_limit_sel;
	logic [4:0] grp_width;
	logic [7:0] grp_mask;
	logic [15:0] pid_mask;

	always_comb begin
		cap_word = 32'h0000_0000;
		if (PART_ON) begin
			cap_word[`SXRP_CAP_ALT_BIT] = ALT_SPACE; // see R12
			cap_word[`SXRP_CAP_GRP_HI:`SXRP_CAP_GRP_LO] = S_GRP_LIMIT;
			cap_word[`SXRP_CAP_PID_HI:`SXRP_CAP_PID_LO] = S_PID_LIMIT; // see R15
		end
	end

	// ============================================================
	// Global configuration register and update handshake
	logic [31:0] cfg_reg;
	logic [31:0] cfg_next;
	sxrp_pkg::sxrp_upd_state_t upd_reg;
	sxrp_pkg::sxrp_upd_state_t upd_next;
	logic apply_req_reg;
	logic apply_req_next;
	logic [7:0] grp_out_reg;
	logic [7:0] grp_out_next;
	logic [15:0] pid_out_reg;
	logic [15:0] pid_out_next;
	logic space_out_reg;
	logic space_out_next;
	logic cfg_wr;
	logic space_sel;
	logic alt_sel;

	// The widths follow the space being stored, so a write that switches
	// space is trimmed to the limits of the space it selects.
	assign space_sel = cfg_wr ? reg_wdata_i[`SXRP_CFG_SPACE_BIT]
		: cfg_reg[`SXRP_CFG_SPACE_BIT];
	assign alt_sel = ALT_SPACE && space_sel;

	always_comb begin
		grp_limit_sel = alt_sel ? ns_grp_limit_i : S_GRP_LIMIT; // see R19
	end

	sxrp_id_width u_width (
		.grp_limit_i(grp_limit_sel),
		.pid_limit_i(alt_sel ? ns_pid_limit_i : S_PID_LIMIT),
		.grp_width_o(grp_width),
		.pid_width_o(),
		.grp_mask_o(grp_mask),
		.pid_mask_o(pid_mask)
	);

	assign cfg_wr = PART_ON && reg_req_i && reg_write_i && reg_secure_i
		&& reg_addr_i == `SXRP_OFF_GLOBAL_CFG
		&& !cfg_reg[`SXRP_CFG_UPDATE_BIT]; // see R22

	always_comb begin
		cfg_next = cfg_reg;
		upd_next = upd_reg;
		apply_req_next = 1'b0;
		if (cfg_wr) begin
			cfg_next[`SXRP_CFG_UPDATE_BIT] = reg_wdata_i[`SXRP_CFG_UPDATE_BIT];
			cfg_next[`SXRP_CFG_SPACE_BIT] = ALT_SPACE
				&& reg_wdata_i[`SXRP_CFG_SPACE_BIT]; // see R17
			cfg_next[`SXRP_CFG_GRP_HI:`SXRP_CFG_GRP_LO] =
				reg_wdata_i[`SXRP_CFG_GRP_HI:`SXRP_CFG_GRP_LO]; // see R18
			cfg_next[`SXRP_CFG_PID_HI:`SXRP_CFG_PID_LO] =
				reg_wdata_i[`SXRP_CFG_PID_HI:`SXRP_CFG_PID_LO]; // see R21
		end
		// Bits above the width of the selected limit never store.
		cfg_next[`SXRP_CFG_GRP_HI:`SXRP_CFG_GRP_LO] =
			cfg_next[`SXRP_CFG_GRP_HI:`SXRP_CFG_GRP_LO] & grp_mask; // see R20
		cfg_next[`SXRP_CFG_PID_HI:`SXRP_CFG_PID_LO] =
			cfg_next[`SXRP_CFG_PID_HI:`SXRP_CFG_PID_LO] & pid_mask;
		case (upd_reg)
			sxrp_pkg::SXRP_UPD_IDLE: begin
				if (cfg_reg[`SXRP_CFG_UPDATE_BIT]) begin
					upd_next = sxrp_pkg::SXRP_UPD_WAIT;
					apply_req_next = 1'b1;
				end
			end
			sxrp_pkg::SXRP_UPD_WAIT: begin
				apply_req_next = 1'b1;
				if (apply_ack_i) begin
					apply_req_next = 1'b0;
					upd_next = sxrp_pkg::SXRP_UPD_DONE;
				end
			end
			sxrp_pkg::SXRP_UPD_DONE: begin
				cfg_next[`SXRP_CFG_UPDATE_BIT] = 1'b0; // see R23
				upd_next = sxrp_pkg::SXRP_UPD_IDLE;
			end
			default: begin
				upd_next = sxrp_pkg::SXRP_UPD_IDLE;
			end
		endcase
	end

	// New identifiers are published only at the acknowledge, so traffic
	// never sees a half-written set of values.
	always_comb begin
		grp_out_next = grp_out_reg;
		pid_out_next = pid_out_reg;
		space_out_next = space_out_reg;
		if (upd_reg == sxrp_pkg::SXRP_UPD_WAIT && apply_ack_i) begin
			grp_out_next = cfg_reg[`SXRP_CFG_GRP_HI:`SXRP_CFG_GRP_LO];
			pid_out_next = cfg_reg[`SXRP_CFG_PID_HI:`SXRP_CFG_PID_LO];
			space_out_next = cfg_reg[`SXRP_CFG_SPACE_BIT];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			cfg_reg <= `SXRP_CFG_RESET; // see R16
			upd_reg <= sxrp_pkg::SXRP_UPD_IDLE;
			apply_req_reg <= 1'b0;
			grp_out_reg <= 8'h00;
			pid_out_reg <= 16'h0000;
			space_out_reg <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
			upd_reg <= upd_next;
			apply_req_reg <= apply_req_next;
			grp_out_reg <= grp_out_next;
			pid_out_reg <= pid_out_next;
			space_out_reg <= space_out_next;
		end
	end

	assign apply_req_o = apply_req_reg;
	assign internal_monitor_group_o = grp_out_reg;
	assign internal_partition_id_o = pid_out_reg;
	assign internal_space_ns_o = space_out_reg;

	// ============================================================
	// Register read port
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;

	always_comb begin
		rdata_next = 32'h0000_0000;
		if (!reg_req_i || reg_write_i || !reg_secure_i) begin
			rdata_next = 32'h0000_0000; // see R10
		end else if (reg_addr_i == `SXRP_OFF_RESULT_LO) begin
			rdata_next = result_reg[31:0];
		end else if (reg_addr_i == `SXRP_OFF_RESULT_HI) begin
			rdata_next = result_reg[63:32];
		end else if (reg_addr_i == `SXRP_OFF_CAPABILITY) begin
			rdata_next = cap_word; // see R11
		end else if (reg_addr_i == `SXRP_OFF_GLOBAL_CFG) begin
			rdata_next = PART_ON ? cfg_reg : 32'h0000_0000;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			rdata_reg <= 32'h0000_0000;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata_o = rdata_reg;

	// ============================================================
	// Checks
	chk_nonsec_raz: assert property ( // see R10
		@(posedge core_clk_i) disable iff (!reset_n_i)
		reg_req_i && !reg_secure_i |=> reg_rdata_o == 32'h0000_0000)
		else $error("non-secure read returned data");
	chk_fault_flag: assert property ( // see R7
		@(posedge core_clk_i) disable iff (!reset_n_i)
		fault_valid_i |=> result_reg[0] && result_reg[59:52] == 8'h00)
		else $error("fault flag or reserved bits wrong");
	chk_ias_ns_zero: assert property ( // see R5
		@(posedge core_clk_i) disable iff (!reset_n_i)
		fault_valid_i && !fault_stream_secure_i |=> !result_reg[3])
		else $error("space bit set for non-secure stream");
	chk_ias_bypass: assert property ( // see R4
		@(posedge core_clk_i) disable iff (!reset_n_i)
		fault_valid_i && fault_stream_secure_i && fault_addr_valid_i
		&& fault_s1_bypassed_i && SECURE_S2
		|=> result_reg[3] == $past(fault_input_ns_i))
		else $error("bypass space bit mismatch");
	chk_class_copy: assert property ( // see R6
		@(posedge core_clk_i) disable iff (!reset_n_i)
		fault_valid_i |=> result_reg[2:1] == $past(fault_class_i))
		else $error("stage class mismatch");
	chk_cfg_locked: assert property ( // see R22
		@(posedge core_clk_i) disable iff (!reset_n_i)
		cfg_reg[31] && upd_reg == sxrp_pkg::SXRP_UPD_IDLE
		|=> cfg_reg[23:0] == $past(cfg_reg[23:0]))
		else $error("configuration changed while update pending");
	chk_update_clear: assert property ( // see R23
		@(posedge core_clk_i) disable iff (!reset_n_i)
		upd_reg == sxrp_pkg::SXRP_UPD_WAIT && apply_ack_i
		|=> ##1 !cfg_reg[31] && grp_out_reg == $past(cfg_reg[23:16], 2))
		else $error("update flag not cleared after apply");
	chk_grp_width: assert property ( // see R20
		@(posedge core_clk_i) disable iff (!reset_n_i)
		1'b1 |=> (cfg_reg[23:16] & ~$past(grp_mask)) == 8'h00
		&& (cfg_reg[15:0] & ~$past(pid_mask)) == 16'h0000)
		else $error("identifier above supported width");
	chk_space_write: assert property ( // see R17
		@(posedge core_clk_i) disable iff (!reset_n_i)
		cfg_wr |=> cfg_reg[24] == (ALT_SPACE && $past(reg_wdata_i[24])))
		else $error("space select stored wrongly");
	chk_cap_width: assert property ( // see R13
		@(posedge core_clk_i) disable iff (!reset_n_i)
		!alt_sel |-> grp_width == 5'($clog2(int'(S_GRP_LIMIT) + 1)))
		else $error("monitor group width wrong");
endmodule : sxrp_regs

// >>> hdl/sxrp_result_fmt.sv
// Builds the 64-bit fault-format translation result word.
`timescale 1ns/100ps
`include "sxrp_defines.svh"
module sxrp_result_fmt #(
	parameter bit SECURE_S2 = 1'b1,
	parameter bit ADDR_52BIT = 1'b1
) (
	sxrp_fault_if.format flt
);
	logic ias_ns;
	logic [39:0] addr;

	always_comb begin
		// Stage 1 bypass reports the request's own input attribute.
		if (!SECURE_S2 || !flt.fault.stream_secure || !flt.fault.addr_valid) begin
			ias_ns = 1'b0; // see R5
		end else if (flt.fault.s1_bypassed) begin
			ias_ns = flt.fault.input_ns; // see R4
		end else begin
			ias_ns = flt.fault.final_ns_s1; // see R3
		end
		addr = flt.fault.addr_valid ? flt.fault.page_addr : 40'h00_0000_0000;
		if (!ADDR_52BIT) begin
			addr[39:36] = 4'h0; // see R2
		end
		flt.word = 64'h0000_0000_0000_0000;
		flt.word[`SXRP_RES_IMPL_HI:`SXRP_RES_IMPL_LO] = flt.fault.impl_bits; // see R1
		flt.word[`SXRP_RES_ADDR_HI:`SXRP_RES_ADDR_LO] = addr;
		flt.word[`SXRP_RES_CODE_HI:`SXRP_RES_CODE_LO] = flt.fault.code;
		flt.word[`SXRP_RES_IAS_BIT] = ias_ns;
		flt.word[`SXRP_RES_CLASS_HI:`SXRP_RES_CLASS_LO] = flt.fault.stage_class; // see R6
		flt.word[`SXRP_RES_FAIL_BIT] = 1'b1; // see R7
	end
endmodule : sxrp_result_fmt

// >>> verif/sxrp_regs_tb.sv
// Self-checking testbench for the secure partition register slice.
`timescale 1ns/100ps
`include "sxrp_defines.svh"
module sxrp_regs_tb;
	localparam logic [7:0] S_GRP = 8'h0F;
	localparam logic [15:0] S_PID = 16'h0034;
	localparam logic [15:0] CAP = `SXRP_OFF_CAPABILITY;
	localparam logic [15:0] CFG = `SXRP_OFF_GLOBAL_CFG;
	localparam logic [15:0] LO = `SXRP_OFF_RESULT_LO;
	localparam logic [15:0] HI = `SXRP_OFF_RESULT_HI;

	logic core_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic reg_req_i = 1'b0;
	logic reg_write_i = 1'b0;
	logic reg_secure_i = 1'b0;
	logic [15:0] reg_addr_i = 16'h0000;
	logic [31:0] reg_wdata_i = 32'h0000_0000;
	logic [31:0] reg_rdata_o;
	logic fault_valid_i = 1'b0;
	logic [3:0] fault_impl_i = 4'h0;
	logic [39:0] fault_addr_i = 40'h00_0000_0000;
	logic fault_addr_valid_i = 1'b0;
	logic [7:0] fault_code_i = 8'h00;
	logic fault_stream_secure_i = 1'b0;
	logic fault_s1_bypassed_i = 1'b0;
	logic fault_input_ns_i = 1'b0;
	logic fault_final_ns_i = 1'b0;
	logic [1:0] fault_class_i = 2'h0;
	logic [7:0] ns_grp_limit_i = 8'h03;
	logic op_active_i = 1'b0;
	logic [15:0] ns_pid_limit_i = 16'h0100;
	logic apply_ack_i = 1'b0;
	logic apply_req_o;
	logic internal_space_ns_o;
	logic [7:0] internal_monitor_group_o;
	logic [15:0] internal_partition_id_o;
	logic [31:0] rd;
	logic [63:0] exp_res;
	int miscompares = 0;
	int samples_checked = 0;

	sxrp_regs #(.S_GRP_LIMIT(S_GRP), .S_PID_LIMIT(S_PID)) i_sxrp_regs (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.reg_req_i(reg_req_i),
		.reg_write_i(reg_write_i),
		.reg_secure_i(reg_secure_i),
		.reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o),
		.op_active_i(op_active_i),
		.fault_valid_i(fault_valid_i),
		.fault_impl_i(fault_impl_i),
		.fault_addr_i(fault_addr_i),
		.fault_addr_valid_i(fault_addr_valid_i),
		.fault_code_i(fault_code_i),
		.fault_stream_secure_i(fault_stream_secure_i),
		.fault_s1_bypassed_i(fault_s1_bypassed_i),
		.fault_input_ns_i(fault_input_ns_i),
		.fault_final_ns_i(fault_final_ns_i),
		.fault_class_i(fault_class_i),
		.ns_grp_limit_i(ns_grp_limit_i),
		.ns_pid_limit_i(ns_pid_limit_i),
		.apply_ack_i(apply_ack_i),
		.apply_req_o(apply_req_o),
		.internal_space_ns_o(internal_space_ns_o),
		.internal_monitor_group_o(internal_monitor_group_o),
		.internal_partition_id_o(internal_partition_id_o)
	);

	// ==========================================================
	// Clock and watchdog
	initial begin
		forever #5 core_clk_i = ~core_clk_i;
	end

	// The whole sequence needs well under 500 cycles.
	initial begin
		#20000;
		miscompares++;
		summarize();
	end

	// ==========================================================
	// Access tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk

	// Read data is registered, so it is sampled just after the taking edge.
	task automatic acc(input logic wr, input logic sec, input logic [15:0] a,
		input logic [31:0] d);
		@(posedge core_clk_i);
		reg_req_i <= 1'b1;
		reg_write_i <= wr;
		reg_secure_i <= sec;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge core_clk_i);
		reg_req_i <= 1'b0;
		#1;
		rd = reg_rdata_o;
	endtask : acc

	task automatic rd_chk(input logic sec, input logic [15:0] a,
		input logic [31:0] exp);
		acc(1'b0, sec, a, 32'h0000_0000);
		chk(rd, exp);
	endtask : rd_chk

	task automatic fault(input logic [3:0] im, input logic [39:0] ad,
		input logic av, input logic [7:0] cd, input logic sec, byp, ins, fns,
		input logic [1:0] cl);
		logic ias;
		// The operation runs a cycle before its fault lands, and the
		// request fields stay untouched until it has ended.
		@(posedge core_clk_i);
		op_active_i <= 1'b1;
		@(posedge core_clk_i);
		fault_valid_i <= 1'b1;
		fault_impl_i <= im;
		fault_addr_i <= ad;
		fault_addr_valid_i <= av;
		fault_code_i <= cd;
		fault_stream_secure_i <= sec;
		fault_s1_bypassed_i <= byp;
		fault_input_ns_i <= ins;
		fault_final_ns_i <= fns;
		fault_class_i <= cl;
		@(posedge core_clk_i);
		fault_valid_i <= 1'b0;
		op_active_i <= 1'b0;
		ias = (!av || !sec) ? 1'b0 : (byp ? ins : fns);
		exp_res = {im, 8'h00, ad, cd, ias, cl, 1'b1};
		rd_chk(1'b1, LO, exp_res[31:0]);
		rd_chk(1'b1, HI, exp_res[63:32]);
	endtask : fault

	task automatic ack_and_check(input logic sp, input logic [7:0] pg,
		input logic [15:0] pid);
		chk({31'h0, apply_req_o}, 32'h0000_0001);
		@(posedge core_clk_i);
		apply_ack_i <= 1'b1;
		@(posedge core_clk_i);
		apply_ack_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		#1;
		chk({31'h0, apply_req_o}, 32'h0000_0000);
		chk({7'h00, internal_space_ns_o, internal_monitor_group_o,
			internal_partition_id_o}, {7'h00, sp, pg, pid});
	endtask : ack_and_check

	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : summarize

	// ==========================================================
	// Test sequence
	initial begin
		repeat (20) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		rd_chk(1'b1, CAP, {6'h00, 1'b1, 1'b0, S_GRP, S_PID});
		rd_chk(1'b1, CFG, 32'h0000_0000);
		rd_chk(1'b1, LO, 32'h0000_0000);
		chk({7'h00, internal_space_ns_o, internal_monitor_group_o,
			internal_partition_id_o}, 32'h0000_0000);
		$display("test reset_values done");

		for (int i = 0; i < 8; i++) begin
			fault(4'(i + 5), 40'hF_0123_4567 + 40'(i), 1'b1, 8'(i + 16),
				1'b1, i[2], i[0], ~i[0], i[1:0]);
		end
		fault(4'hF, 40'h00_0000_0000, 1'b0, 8'h21, 1'b1, 1'b0, 1'b1, 1'b1,
			2'h3);
		fault(4'h1, 40'h12_3456_789A, 1'b1, 8'h22, 1'b0, 1'b1, 1'b1, 1'b1,
			2'h2);
		$display("test fault_results done");

		rd_chk(1'b0, LO, 32'h0000_0000);
		rd_chk(1'b0, HI, 32'h0000_0000);
		rd_chk(1'b0, CAP, 32'h0000_0000);
		acc(1'b1, 1'b0, CFG, 32'h0003_0001);
		rd_chk(1'b0, CFG, 32'h0000_0000);
		rd_chk(1'b1, CFG, 32'h0000_0000);
		acc(1'b1, 1'b1, LO, 32'hFFFF_FFFF);
		acc(1'b1, 1'b1, CAP, 32'hFFFF_FFFF);
		rd_chk(1'b1, LO, exp_res[31:0]);
		rd_chk(1'b1, CAP, {6'h00, 1'b1, 1'b0, S_GRP, S_PID});
		rd_chk(1'b1, 16'h8120, 32'h0000_0000);
		$display("test access_rights done");

		acc(1'b1, 1'b1, CFG, 32'h8003_0005);
		rd_chk(1'b1, CFG, 32'h8003_0005);
		acc(1'b1, 1'b1, CFG, 32'h0000_0000);
		rd_chk(1'b1, CFG, 32'h8003_0005);
		ack_and_check(1'b0, 8'h03, 16'h0005);
		rd_chk(1'b1, CFG, 32'h0003_0005);
		$display("test update_flow done");

		// Secure limits 0x0F and 0x0034 give widths of 4 and 6 bits.
		acc(1'b1, 1'b1, CFG, 32'h00FF_FFFF);
		rd_chk(1'b1, CFG, 32'h000F_003F);
		// Non-secure limits 0x03 and 0x0100 give widths of 2 and 9 bits.
		acc(1'b1, 1'b1, CFG, 32'h81FF_FFFF);
		rd_chk(1'b1, CFG, 32'h8103_01FF);
		ack_and_check(1'b1, 8'h03, 16'h01FF);
		rd_chk(1'b1, CFG, 32'h0103_01FF);
		$display("test id_widths done");
		summarize();
	end
endmodule : sxrp_regs_tb
